// [scr_pkg.sv]
// Package for the secondary configuration register slice.
// Assumes a single core clock domain and plain register port access.
package scr_pkg;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] ARB_PRIO_OFS   = 8'h48;
    localparam logic [7:0] LINE_LAT_OFS   = 8'h4C;
    localparam logic [7:0] CSR_WIN_OFS    = 8'h50;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int         PRIO_BRIDGE_BIT = 22;
    localparam int         PRIO_EXT_LSB    = 23;
    localparam int         PRIO_EXT_N      = 8;
    localparam logic       PRIO_BRIDGE_RST = 1'b1;
    localparam logic [7:0] PRIO_EXT_RST    = 8'h00;
    localparam int         LINE_LSB        = 2;
    localparam logic [3:0] LINE_RST        = 4'h0;
    localparam int         LAT_LSB         = 8;
    localparam logic [7:0] LAT_RST_PCI     = 8'h00;
    localparam logic [7:0] LAT_RST_PCIX    = 8'h40;
    localparam int         HDR_CFG_LSB     = 16;
    localparam logic [6:0] HDR_CFG_VAL     = 7'h00;
    localparam logic       HDR_MULTI_VAL   = 1'b0;
    localparam int         BASE_LSB        = 12;
    localparam logic [19:0] BASE_RST       = 20'h00000;
    localparam logic [2:0] ADDR_TYPE_LSB   = 3'h1;
    localparam logic [1:0] ADDR_TYPE_VAL   = 2'h0;
    localparam logic       PREFETCH_VAL    = 1'b0;
    localparam logic       SPACE_VAL       = 1'b0;

    // Window decode output bundle
    typedef struct packed {
        logic        enable;
        logic [19:0] base;
        logic [19:0] mask;
    } scr_window_t;

endpackage

// [scr_regs.sv]
// Secondary configuration registers: arbiter priority, line size,
// latency timer, header kind and CSR/memory window base.
// Assumes strobes synchronous to core_clk; setup mask from same domain.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module scr_regs (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Bridge mode straps
    input  wire logic                 forward_mode,
    input  wire logic                 pcix_mode,
    // Upstream memory 0 setup and translated base
    input  wire logic [19:0]          setup_mask,
    input  wire logic [19:0]          xlat_base,
    // Window address lookup
    input  wire logic [31:0]          probe_addr,
    output logic                      hit_csr,
    output logic                      hit_fwd,
    output logic      [31:0]          fwd_addr,
    // Arbiter priorities, line size, latency and window to the rest of the bridge
    output logic      [8:0]           arb_prio,
    output logic      [3:0]           line_size,
    output logic      [7:0]           latency,
    output scr_pkg::scr_window_t      window
);

    // ********************************************************************
    // Configuration state
    // ********************************************************************
    logic        prio_br_q,  prio_br_d;
    logic [7:0]  prio_ext_q, prio_ext_d;
    logic [3:0]  line_q,     line_d;
    logic [7:0]  lat_q,      lat_d;
    logic [19:0] base_q,     base_d;
    logic        fwd_q,      fwd_d;
    logic [31:0] rdata_q,    rdata_d;
    logic        hit_csr_q,  hit_csr_d;
    logic        hit_fwd_q,  hit_fwd_d;
    logic [31:0] fwd_addr_q, fwd_addr_d;
    logic        win_en;
    logic [19:0] off_bits;
    scr_pkg::scr_window_t win_q, win_d;

    // Mode straps are pins: two-flop synchronisers
    logic        fwd_s1_q, fwd_s2_q, pcix_s1_q, pcix_s2_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fwd_s1_q  <= 1'b0;
            fwd_s2_q  <= 1'b0;
            pcix_s1_q <= 1'b0;
            pcix_s2_q <= 1'b0;
        end else begin
            fwd_s1_q  <= forward_mode;
            fwd_s2_q  <= fwd_s1_q;
            pcix_s1_q <= pcix_mode;
            pcix_s2_q <= pcix_s1_q;
        end
    end

    // ********************************************************************
    // Register write logic
    // ********************************************************************
    always_comb begin
        prio_br_d  = prio_br_q;
        prio_ext_d = prio_ext_q;
        line_d     = line_q;
        lat_d      = lat_q;
        base_d     = base_q;
        fwd_d      = fwd_s2_q;
        // Reverse bridge forces latency to zero
        if (!fwd_s2_q) begin
            lat_d = scr_pkg::LAT_RST_PCI;
        end else if (!fwd_q) begin
            // Entering forward mode loads mode-dependent default
            lat_d = pcix_s2_q ? scr_pkg::LAT_RST_PCIX : scr_pkg::LAT_RST_PCI;
        end
        if (reg_wr) begin
            case (reg_addr)
                scr_pkg::ARB_PRIO_OFS: begin
                    prio_br_d  = reg_wdata[scr_pkg::PRIO_BRIDGE_BIT];
                    prio_ext_d = reg_wdata[scr_pkg::PRIO_EXT_LSB +: 8];
                end
                scr_pkg::LINE_LAT_OFS: begin
                    line_d = reg_wdata[scr_pkg::LINE_LSB +: 4];
                    if (fwd_s2_q && fwd_q) begin
                        lat_d = reg_wdata[scr_pkg::LAT_LSB +: 8];
                    end
                end
                scr_pkg::CSR_WIN_OFS: begin
                    // Only setup-enabled bits take the write
                    base_d = (base_q & ~setup_mask)
                           | (reg_wdata[31:scr_pkg::BASE_LSB] & setup_mask);
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************************************************
    // Read data, fixed fields
    // ********************************************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                scr_pkg::ARB_PRIO_OFS: begin
                    rdata_d[scr_pkg::PRIO_BRIDGE_BIT]  = prio_br_q;
                    rdata_d[scr_pkg::PRIO_EXT_LSB +: 8] = prio_ext_q;
                end
                scr_pkg::LINE_LAT_OFS: begin
                    rdata_d[1:0] = 2'h0;
                    rdata_d[scr_pkg::LINE_LSB +: 4] = line_q;
                    rdata_d[7:6] = 2'h0;
                    rdata_d[scr_pkg::LAT_LSB +: 8] = lat_q;
                    rdata_d[scr_pkg::HDR_CFG_LSB +: 7] = scr_pkg::HDR_CFG_VAL;
                    rdata_d[23] = scr_pkg::HDR_MULTI_VAL;
                end
                scr_pkg::CSR_WIN_OFS: begin
                    rdata_d[0]   = scr_pkg::SPACE_VAL;
                    rdata_d[2:1] = scr_pkg::ADDR_TYPE_VAL;
                    rdata_d[3]   = scr_pkg::PREFETCH_VAL;
                    rdata_d[31:scr_pkg::BASE_LSB] = base_q;
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************************************************
    // Window decode and translation
    // ********************************************************************
    assign win_en   = (base_q != 20'h00000);
    assign off_bits = probe_addr[31:scr_pkg::BASE_LSB] & ~setup_mask;

    always_comb begin
        hit_csr_d  = 1'b0;
        hit_fwd_d  = 1'b0;
        fwd_addr_d = 32'h0000_0000;
        // Registered window view; mask lags its input by one cycle
        win_d.enable = (base_d != 20'h00000);
        win_d.base   = base_d;
        win_d.mask   = setup_mask;
        // Size set by setup mask: 4KB up to 2GB
        if (win_en && ((probe_addr[31:scr_pkg::BASE_LSB] & setup_mask)
                       == (base_q & setup_mask))) begin
            if (off_bits == 20'h00000) begin
                hit_csr_d = 1'b1;
            end else begin
                hit_fwd_d  = 1'b1;
                fwd_addr_d = {(xlat_base & setup_mask) | off_bits,
                              probe_addr[scr_pkg::BASE_LSB-1:0]};
            end
        end
    end

    // ********************************************************************
    // State registers
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prio_br_q  <= scr_pkg::PRIO_BRIDGE_RST;
            prio_ext_q <= scr_pkg::PRIO_EXT_RST;
            line_q     <= scr_pkg::LINE_RST;
            lat_q      <= scr_pkg::LAT_RST_PCI;
            base_q     <= scr_pkg::BASE_RST;
            fwd_q      <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            hit_csr_q  <= 1'b0;
            hit_fwd_q  <= 1'b0;
            fwd_addr_q <= 32'h0000_0000;
            win_q      <= '{enable: 1'b0, base: scr_pkg::BASE_RST, mask: 20'h00000};
        end else begin
            prio_br_q  <= prio_br_d;
            prio_ext_q <= prio_ext_d;
            line_q     <= line_d;
            lat_q      <= lat_d;
            base_q     <= base_d;
            fwd_q      <= fwd_d;
            rdata_q    <= rdata_d;
            hit_csr_q  <= hit_csr_d;
            hit_fwd_q  <= hit_fwd_d;
            fwd_addr_q <= fwd_addr_d;
            win_q      <= win_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata      = rdata_q;
    assign hit_csr        = hit_csr_q;
    assign hit_fwd        = hit_fwd_q;
    assign fwd_addr       = fwd_addr_q;
    assign arb_prio       = {prio_ext_q, prio_br_q};
    assign line_size      = line_q;
    assign latency        = lat_q;
    assign window         = win_q;

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_prio_write;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && reg_addr == scr_pkg::ARB_PRIO_OFS) |=>
            arb_prio == $past(reg_wdata[30:22]);
    endproperty
    a_prio_write: assert property (p_prio_write) else $error("priority write lost");

    property p_prio_reset;
        @(posedge core_clk) $fell(reset) |-> arb_prio == 9'h001;
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priority reset wrong");

    property p_line_read;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && reg_addr == scr_pkg::LINE_LAT_OFS) |=>
            reg_rdata[1:0] == 2'h0 && reg_rdata[7:6] == 2'h0
            && reg_rdata[5:2] == $past(line_size) && reg_rdata[31:16] == 16'h0000;
    endproperty
    a_line_read: assert property (p_line_read) else $error("line size read wrong");

    property p_rev_latency;
        @(posedge core_clk) disable iff (reset)
        (!fwd_s2_q)[*2] |-> latency == 8'h00;
    endproperty
    a_rev_latency: assert property (p_rev_latency) else $error("reverse latency nonzero");

    property p_fwd_entry;
        @(posedge core_clk) disable iff (reset)
        (fwd_s2_q && !fwd_q && !reg_wr) |=>
            latency == ($past(pcix_s2_q) ? 8'h40 : 8'h00);
    endproperty
    a_fwd_entry: assert property (p_fwd_entry) else $error("latency default wrong");

    property p_base_mask;
        @(posedge core_clk) disable iff (reset)
        ((base_q & ~setup_mask) == 20'h00000) |=> ((base_q & ~$past(setup_mask)) == 20'h00000);
    endproperty
    a_base_mask: assert property (p_base_mask) else $error("masked base bit changed");

    property p_win_read;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && reg_addr == scr_pkg::CSR_WIN_OFS) |=>
            reg_rdata[11:0] == 12'h000 && reg_rdata[31:12] == $past(base_q);
    endproperty
    a_win_read: assert property (p_win_read) else $error("window read wrong");

    property p_disabled;
        @(posedge core_clk) disable iff (reset)
        (base_q == 20'h00000) |=> !hit_csr && !hit_fwd;
    endproperty
    a_disabled: assert property (p_disabled) else $error("hit while disabled");

    property p_one_hit;
        @(posedge core_clk) disable iff (reset)
        !(hit_csr && hit_fwd) && (!hit_fwd || fwd_addr[11:0] == $past(probe_addr[11:0]));
    endproperty
    a_one_hit: assert property (p_one_hit) else $error("hit decode wrong");

    property p_rdata_idle;
        @(posedge core_clk) disable iff (reset)
        !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    property p_unmapped_read;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && reg_addr != scr_pkg::ARB_PRIO_OFS && reg_addr != scr_pkg::LINE_LAT_OFS
         && reg_addr != scr_pkg::CSR_WIN_OFS) |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    property p_prio_read;
        @(posedge core_clk) disable iff (reset)
        (reg_rd && reg_addr == scr_pkg::ARB_PRIO_OFS) |=>
            reg_rdata[21:0] == 22'h0 && !reg_rdata[31]
            && reg_rdata[30:22] == $past(arb_prio);
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("priority read wrong");

    property p_line_write;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && reg_addr == scr_pkg::LINE_LAT_OFS) |=> line_size == $past(reg_wdata[5:2]);
    endproperty
    a_line_write: assert property (p_line_write) else $error("line size write lost");

    property p_lat_write;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && reg_addr == scr_pkg::LINE_LAT_OFS && fwd_s2_q && fwd_q) |=>
            latency == $past(reg_wdata[15:8]);
    endproperty
    a_lat_write: assert property (p_lat_write) else $error("latency write lost");

    property p_lat_hold;
        @(posedge core_clk) disable iff (reset)
        (!reg_wr && fwd_s2_q && fwd_q) |=> $stable(latency);
    endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("latency changed unwritten");

    property p_win_write;
        @(posedge core_clk) disable iff (reset)
        (reg_wr && reg_addr == scr_pkg::CSR_WIN_OFS) |=>
            ((window.base ^ $past(reg_wdata[31:12])) & $past(setup_mask)) == 20'h00000;
    endproperty
    a_win_write: assert property (p_win_write) else $error("enabled base bit not written");

    property p_win_enable;
        @(posedge core_clk) disable iff (reset)
        window.enable == (window.base != 20'h00000);
    endproperty
    a_win_enable: assert property (p_win_enable) else $error("window enable wrong");

endmodule

`default_nettype wire

// [tb.sv]
// Testbench for the secondary configuration register slice.
// Assumes scr_pkg and scr_regs are compiled first; drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // Clock, reset and register port
    logic        core_clk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    // Straps, setup and lookup
    logic        forward_mode;
    logic        pcix_mode;
    logic [19:0] setup_mask;
    logic [19:0] xlat_base;
    logic [31:0] probe_addr;
    logic        hit_csr;
    logic        hit_fwd;
    logic [31:0] fwd_addr;
    logic [8:0]  arb_prio;
    logic [3:0]  line_size;
    logic [7:0]  latency;
    scr_pkg::scr_window_t window;
    int          miscompares;
    int          num_checks;

    scr_regs dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .forward_mode(forward_mode), .pcix_mode(pcix_mode), .setup_mask(setup_mask),
        .xlat_base(xlat_base), .probe_addr(probe_addr), .hit_csr(hit_csr),
        .hit_fwd(hit_fwd), .fwd_addr(fwd_addr), .arb_prio(arb_prio),
        .line_size(line_size), .latency(latency), .window(window));

    // ********************************************************************
    // Clock and shared tasks
    // ********************************************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Compare one value and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Read and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // Registered window lookup
    task automatic probe(input logic [31:0] a, input logic c, input logic f,
                         input logic [31:0] fa);
        @(posedge core_clk);
        probe_addr <= a;
        @(posedge core_clk);
        #1;
        chk(32'(hit_csr), 32'(c));
        chk(32'(hit_fwd), 32'(f));
        chk(fwd_addr, fa);
    endtask

    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        finish_test();
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        miscompares = 0;
        num_checks  = 0;
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        forward_mode = 1'b0;
        pcix_mode = 1'b0;
        setup_mask = 20'hFFFF0;
        xlat_base = 20'hABCDE;
        probe_addr = 32'h0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        // Reset values
        chk(32'(arb_prio), 32'h001);
        rchk(8'h48, 32'h0040_0000);
        chk(reg_rdata, 32'h0040_0000);
        @(posedge core_clk);
        #1;
        chk(reg_rdata, 32'h0); // read data stands one cycle only
        rchk(8'h4C, 32'h0);
        rchk(8'h50, 32'h0);
        // Priority field order and write-through
        wr(8'h48, 32'hAAAA_AAAA);
        rchk(8'h48, 32'h2A80_0000);
        chk(32'(arb_prio), 32'h0AA);
        wr(8'h48, 32'h5555_5555);
        rchk(8'h48, 32'h5540_0000);
        chk(32'(arb_prio), 32'h155);
        // Line size and fixed bits, reverse bridge latency stays zero
        wr(8'h4C, 32'hFFFF_FFFF);
        rchk(8'h4C, 32'h0000_003C);
        chk(32'(line_size), 32'hF);
        chk(32'(latency), 32'h00);
        // Forward bridge, PCI-X default then writable
        @(posedge core_clk);
        forward_mode <= 1'b1;
        pcix_mode    <= 1'b1;
        repeat (8) @(posedge core_clk);
        rchk(8'h4C, 32'h0000_403C);
        wr(8'h4C, 32'h0000_1204);
        rchk(8'h4C, 32'h0000_1204);
        chk(32'(latency), 32'h12);
        // Back to reverse, then forward in PCI mode
        @(posedge core_clk);
        forward_mode <= 1'b0;
        pcix_mode    <= 1'b0;
        repeat (8) @(posedge core_clk);
        wr(8'h4C, 32'h0000_7700);
        rchk(8'h4C, 32'h0);
        @(posedge core_clk);
        forward_mode <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(32'(latency), 32'h00);
        wr(8'h4C, 32'h0000_3308);
        rchk(8'h4C, 32'h0000_3308);
        // Base writable only under setup bits
        wr(8'h50, 32'hFFFF_FFFF);
        rchk(8'h50, 32'hFFFF_0000);
        wr(8'h50, 32'h1234_5ABC);
        rchk(8'h50, 32'h1234_0000);
        chk(32'(window.enable), 32'h1);
        chk(32'(window.base), 32'h12340);
        chk(32'(window.mask), 32'hFFFF0);
        // Lookups: own CSR page, forwarded part, outside
        probe(32'h1234_0FFF, 1'b1, 1'b0, 32'h0);
        probe(32'h1234_F004, 1'b0, 1'b1, 32'hABCD_F004);
        probe(32'h1235_0000, 1'b0, 1'b0, 32'h0);
        // Zero base disables the window
        wr(8'h50, 32'h0);
        #1;
        chk(32'(window.enable), 32'h0);
        probe(32'h0000_0100, 1'b0, 1'b0, 32'h0);
        // Unmapped offset
        wr(8'h54, 32'hFFFF_FFFF);
        rchk(8'h54, 32'h0);
        rchk(8'h48, 32'h5540_0000);
        // Mid-run reset in forward PCI-X mode: latency default 40h
        @(posedge core_clk);
        reset     <= 1'b1;
        pcix_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk(32'(latency), 32'h40);
        chk(32'(arb_prio), 32'h001);
        chk(32'(line_size), 32'h0);
        rchk(8'h50, 32'h0);
        finish_test();
    end
endmodule

`default_nettype wire
